//--- include/smfm_pkg.sv
`default_nettype none
package smfm_pkg;
    // Clock rate and derived timing counts
    localparam int CLK_HZ = 50_000_000;
    localparam int STEP_TIME_US = 200;
    localparam int STEP_CYCLES = STEP_TIME_US * (CLK_HZ / 1_000_000);
    localparam int MON_PERIOD_US = 1800;
    localparam int MON_CYCLES = MON_PERIOD_US * (CLK_HZ / 1_000_000);
    // Glitch filter times in microseconds: 0, 15, 40, 120
    localparam int GLITCH_US_1 = 15;
    localparam int GLITCH_US_2 = 40;
    localparam int GLITCH_US_3 = 120;
    localparam int GLITCH_CYC_1 = GLITCH_US_1 * (CLK_HZ / 1_000_000);
    localparam int GLITCH_CYC_2 = GLITCH_US_2 * (CLK_HZ / 1_000_000);
    localparam int GLITCH_CYC_3 = GLITCH_US_3 * (CLK_HZ / 1_000_000);
    // Margin pin delay in tenths of a millisecond: 2.5, 5, 10, 17.5 ms
    localparam int PIN_DLY_TENTH_MS_0 = 25;
    localparam int PIN_DLY_TENTH_MS_1 = 50;
    localparam int PIN_DLY_TENTH_MS_2 = 100;
    localparam int PIN_DLY_TENTH_MS_3 = 175;
    localparam int CYC_PER_TENTH_MS = CLK_HZ / 10_000;
    localparam int PIN_DLY_CYC_0 = PIN_DLY_TENTH_MS_0 * CYC_PER_TENTH_MS;
    localparam int PIN_DLY_CYC_1 = PIN_DLY_TENTH_MS_1 * CYC_PER_TENTH_MS;
    localparam int PIN_DLY_CYC_2 = PIN_DLY_TENTH_MS_2 * CYC_PER_TENTH_MS;
    localparam int PIN_DLY_CYC_3 = PIN_DLY_TENTH_MS_3 * CYC_PER_TENTH_MS;
    // Trim code width: 256 steps
    localparam int TRIM_W = 8;
    localparam int ADC_W = 10;
    localparam logic [1:0] CMD_NOMINAL = 2'h0;
    localparam logic [1:0] CMD_HIGH = 2'h1;
    localparam logic [1:0] CMD_LOW = 2'h2;
    localparam logic [1:0] CMD_OFF = 2'h3;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h00;

    typedef enum logic [1:0] {
        SMFM_M_OFF,
        SMFM_M_NOM,
        SMFM_M_HIGH,
        SMFM_M_LOW
    } smfm_mode_t;

    typedef struct packed {
        logic vref_high;
        logic [1:0] glitch_sel;
        logic [1:0] pin_delay_sel;
        logic [1:0] over_voltage_mode;
        logic fault_off_margin;
        logic ready_active_high;
        logic latch_on_ready;
    } smfm_cfg_t;

    typedef struct packed {
        logic [1:0] live_fault;
        logic [1:0] latched_fault;
        logic margin_done;
        logic margining;
        logic holdoff_enable;
    } smfm_stat_t;
endpackage
`default_nettype wire

//--- hw/smfm_core.sv
`timescale 1ns/1ps
`default_nettype none
module smfm_core (
    input wire logic clk,
    input wire logic sys_rst,
    input wire smfm_pkg::smfm_cfg_t cfg,
    input wire logic [smfm_pkg::ADC_W-1:0] set_high,
    input wire logic [smfm_pkg::ADC_W-1:0] set_low,
    input wire logic [smfm_pkg::ADC_W-1:0] set_nominal,
    input wire logic [1:0] cmd,
    input wire logic cmd_strobe,
    input wire logic latch_clear,
    input wire logic margin_raise_pin,
    input wire logic margin_lower_pin,
    input wire logic [smfm_pkg::ADC_W-1:0] supply_sense_input,
    input wire logic [smfm_pkg::ADC_W-1:0] trim_sample,
    input wire logic monitor_input_one,
    input wire logic monitor_input_two,
    input wire logic ready_in,
    output logic [smfm_pkg::TRIM_W-1:0] trim_code,
    output logic trim_oe_n,
    output logic vref_sel_high,
    output logic fault_out,
    output logic fault_oe_n,
    output logic ready_out,
    output logic ready_oe_n,
    output smfm_pkg::smfm_stat_t status
);
    import smfm_pkg::*;

    // Pins come from outside the clock domain: two flops each
    logic [4:0] pin_s1_ff;
    logic [4:0] pin_s2_ff;
    always_ff @(posedge clk) begin
        pin_s1_ff <= {ready_in, monitor_input_two, monitor_input_one,
                      margin_lower_pin, margin_raise_pin};
        pin_s2_ff <= pin_s1_ff;
    end
    wire raise_s = pin_s2_ff[0];
    wire lower_s = pin_s2_ff[1];
    wire [1:0] comp_s = pin_s2_ff[3:2];
    wire ready_line_s = pin_s2_ff[4];

    function automatic logic [23:0] pin_delay(input logic [1:0] sel);
        unique case (sel)
            2'h0: pin_delay = 24'(PIN_DLY_CYC_0);
            2'h1: pin_delay = 24'(PIN_DLY_CYC_1);
            2'h2: pin_delay = 24'(PIN_DLY_CYC_2);
            2'h3: pin_delay = 24'(PIN_DLY_CYC_3);
        endcase
    endfunction

    function automatic logic [12:0] glitch_len(input logic [1:0] sel);
        unique case (sel)
            2'h0: glitch_len = 13'h0000;
            2'h1: glitch_len = 13'(GLITCH_CYC_1);
            2'h2: glitch_len = 13'(GLITCH_CYC_2);
            2'h3: glitch_len = 13'(GLITCH_CYC_3);
        endcase
    endfunction

    // Glitch filter: a new level must stand for the chosen time
    logic [1:0] comp_f_ff;
    logic [12:0] gl_cnt_ff [2];
    wire [12:0] gl_lim = glitch_len(cfg.glitch_sel);
    // One process for both channels, so each register has a single driver
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (sys_rst || comp_s[i] == comp_f_ff[i]) begin
                gl_cnt_ff[i] <= 13'h0000;
            end else begin
                gl_cnt_ff[i] <= gl_cnt_ff[i] + 13'h0001;
            end
            if (sys_rst) begin
                comp_f_ff[i] <= 1'b0;
            end else if (comp_s[i] != comp_f_ff[i] && gl_cnt_ff[i] >= gl_lim) begin
                comp_f_ff[i] <= comp_s[i];
            end
        end
    end

    // Comparator high means input above reference
    wire [1:0] live_fault = comp_f_ff ^ ~cfg.over_voltage_mode;

    // Margin control
    typedef enum logic [2:0] {ST_IDLE, ST_SAMPLE, ST_STEP, ST_HOLD} smfm_st_t;
    smfm_st_t st_ff, nxt_st;
    smfm_mode_t mode_ff, nxt_mode;
    logic [ADC_W-1:0] target_ff;
    logic [TRIM_W-1:0] code_ff;
    logic [23:0] tick_ff;
    logic [23:0] pin_cnt_ff;
    logic pin_src_ff;
    logic done_ff;

    wire pin_req = raise_s ^ lower_s;
    wire pin_due = pin_req && pin_cnt_ff >= pin_delay(cfg.pin_delay_sel);
    wire pin_go = pin_due && !pin_src_ff;
    wire pin_drop = pin_src_ff && !pin_req;
    wire step_tick = tick_ff >= 24'(STEP_CYCLES - 1);
    wire at_target = supply_sense_input == target_ff;
    wire [1:0] dec_cmd = cmd;
    wire cmd_go = cmd_strobe && dec_cmd != CMD_OFF;
    wire cmd_off = cmd_strobe && dec_cmd == CMD_OFF;

    always_comb begin
        nxt_st = st_ff;
        nxt_mode = mode_ff;
        if (cmd_off || pin_drop) begin
            nxt_st = ST_IDLE;
            nxt_mode = SMFM_M_OFF;
        end else if (cmd_go || pin_go) begin
            nxt_st = ST_SAMPLE;
            if (cmd_go) begin
                nxt_mode = dec_cmd == CMD_HIGH ? SMFM_M_HIGH :
                           dec_cmd == CMD_LOW ? SMFM_M_LOW : SMFM_M_NOM;
            end else begin
                nxt_mode = raise_s ? SMFM_M_HIGH : SMFM_M_LOW;
            end
        end else begin
            unique case (st_ff)
                ST_IDLE: nxt_st = ST_IDLE;
                ST_SAMPLE: nxt_st = ST_STEP;
                ST_STEP: nxt_st = (step_tick && at_target) ? ST_HOLD : ST_STEP;
                ST_HOLD: nxt_st = ST_HOLD;
                default: nxt_st = ST_IDLE;
            endcase
        end
    end

    wire [ADC_W-1:0] nxt_target = nxt_mode == SMFM_M_HIGH ? set_high :
                                  nxt_mode == SMFM_M_LOW ? set_low : set_nominal;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= ST_IDLE;
            mode_ff <= SMFM_M_OFF;
            target_ff <= '0;
            code_ff <= TRIM_RESET;
            tick_ff <= '0;
            pin_cnt_ff <= '0;
            pin_src_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            mode_ff <= nxt_mode;
            pin_cnt_ff <= pin_req ? (pin_due ? pin_cnt_ff : pin_cnt_ff + 24'h00_0001) : '0;
            if (pin_go) begin
                pin_src_ff <= 1'b1;
            end else if (cmd_strobe || !pin_req) begin
                pin_src_ff <= 1'b0;
            end
            if (nxt_st == ST_SAMPLE) begin
                target_ff <= nxt_target;
                // Start from the converter's own operating point
                code_ff <= trim_sample[ADC_W-1 -: TRIM_W];
                tick_ff <= '0;
                done_ff <= 1'b0;
            end else begin
                tick_ff <= step_tick ? '0 : tick_ff + 24'h00_0001;
                if (st_ff == ST_STEP && step_tick && !at_target) begin
                    // Saturate rather than wrap at the ends of the range
                    if (target_ff > supply_sense_input && code_ff != '1) begin
                        code_ff <= code_ff + 8'h01;
                    end else if (target_ff < supply_sense_input && code_ff != '0) begin
                        code_ff <= code_ff - 8'h01;
                    end
                end
                done_ff <= nxt_st == ST_HOLD;
            end
        end
    end

    wire margining = st_ff != ST_IDLE;
    wire hi_lo = mode_ff == SMFM_M_HIGH || mode_ff == SMFM_M_LOW;
    wire fault_now = |live_fault && !(cfg.fault_off_margin && hi_lo);
    wire ready_now = done_ff;

    // Latched status: leading edge of fault, or, when latch_on_ready is set, ready line pulled low instead (only with ready_active_high set)
    logic fault_d_ff;
    logic ready_d_ff;
    logic [1:0] latch_ff;
    wire ready_fall = cfg.ready_active_high && ready_d_ff && !ready_line_s;
    wire fault_rise = fault_now && !fault_d_ff;
    wire latch_ev = cfg.latch_on_ready ? ready_fall : fault_rise;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_d_ff <= 1'b0;
            ready_d_ff <= 1'b0;
            latch_ff <= 2'h0;
            trim_code <= TRIM_RESET;
            trim_oe_n <= 1'b1;
            vref_sel_high <= 1'b0;
            fault_out <= 1'b0;
            fault_oe_n <= 1'b1;
            ready_out <= 1'b0;
            ready_oe_n <= 1'b1;
            status <= '0;
        end else begin
            fault_d_ff <= fault_now;
            ready_d_ff <= ready_line_s;
            // Capture wins over a clear in the same cycle
            if (latch_ev) begin
                latch_ff <= live_fault;
            end else if (latch_clear) begin
                latch_ff <= 2'h0;
            end
            trim_code <= code_ff;
            trim_oe_n <= !margining;
            vref_sel_high <= cfg.vref_high;
            fault_out <= 1'b0;
            fault_oe_n <= !fault_now;
            // Open drain ready: drive low when the pin level should be low
            ready_out <= 1'b0;
            ready_oe_n <= cfg.ready_active_high ? ready_now : !ready_now;
            status.live_fault <= live_fault;
            status.latched_fault <= latch_ev ? live_fault : latch_ff;
            status.margin_done <= done_ff;
            status.margining <= margining;
            status.holdoff_enable <= mode_ff == SMFM_M_NOM;
        end
    end
endmodule // smfm_core
`default_nettype wire

//--- sim/smfm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module smfm_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire smfm_pkg::smfm_cfg_t cfg,
    input wire logic [1:0] cmd,
    input wire logic cmd_strobe,
    input wire logic monitor_input_one,
    input wire logic [smfm_pkg::TRIM_W-1:0] trim_code,
    input wire logic trim_oe_n,
    input wire logic fault_oe_n,
    input wire logic ready_oe_n,
    input wire smfm_pkg::smfm_stat_t status
);
    import smfm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic mute = cfg.fault_off_margin & status.margining & ~status.holdoff_enable;
    // Filtered paths lag by up to 6000 cycles, so timing checks only without filter
    wire logic nofilt = cfg.glitch_sel == 2'h0;
    trim_release_a: assert property (trim_oe_n == !status.margining)
        else $error("trim drive disagrees with margining");
    // The seed load at the start of a cycle may jump; only later moves are steps
    step_size_a: assert property (status.margining && $past(status.margining) &&
        !$past(cmd_strobe, 2) &&
        $changed(trim_code) |-> trim_code == $past(trim_code) + 8'h01 ||
        trim_code == $past(trim_code) - 8'h01) else $error("trim step not one code");
    hold_level_a: assert property (status.margin_done && $past(status.margin_done) &&
        !$past(cmd_strobe) |-> $stable(trim_code)) else $error("trim moved after target");
    off_release_a: assert property (cmd_strobe && cmd == CMD_OFF |-> ##[1:3] trim_oe_n)
        else $error("off command left trim driven");
    cmd_start_a: assert property (cmd_strobe && cmd != CMD_OFF |-> ##2 status.margining)
        else $error("command did not start margining");
    done_ready_a: assert property (status.margin_done |-> ready_oe_n == cfg.ready_active_high)
        else $error("ready not active at target");
    live_map_a: assert property ((nofilt && $stable(monitor_input_one) &&
        $stable(cfg.over_voltage_mode))[*6] |-> status.live_fault[0] ==
        (monitor_input_one ~^ cfg.over_voltage_mode[0])) else $error("live fault bit wrong");
    fault_drive_a: assert property ($rose(|status.live_fault) && nofilt && !mute
        |-> ##[0:3] !fault_oe_n) else $error("fault wire not pulled low");
    fault_free_a: assert property (!fault_oe_n && nofilt |-> (|status.live_fault) ||
        (|$past(status.live_fault)) || (|$past(status.live_fault, 2)))
        else $error("fault wire low without fault");
    margin_mute_a: assert property (mute[*3] |-> fault_oe_n)
        else $error("fault shown while muted");
    cover property ($rose(status.margin_done));
    cover property ($fell(fault_oe_n));
    cover property (cmd_strobe && cmd == CMD_OFF);
endmodule // smfm_checker
bind smfm_core smfm_checker u_chk (.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .cmd(cmd),
    .cmd_strobe(cmd_strobe), .monitor_input_one(monitor_input_one), .trim_code(trim_code),
    .trim_oe_n(trim_oe_n), .fault_oe_n(fault_oe_n), .ready_oe_n(ready_oe_n), .status(status));
`default_nettype wire

//--- sim/smfm_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module smfm_conv_model #(
    parameter logic [7:0] NOM_TRIM = 8'h40
) (
    input wire logic clk,
    input wire logic slow,
    input wire logic [smfm_pkg::TRIM_W-1:0] trim_code,
    input wire logic trim_oe_n,
    output logic [smfm_pkg::ADC_W-1:0] sense,
    output logic [smfm_pkg::ADC_W-1:0] sample
);
    import smfm_pkg::*;
    logic [8:0] lag_ff = 9'h000;
    // Released trim pin floats back to the converter's own set point
    wire logic [TRIM_W-1:0] level = trim_oe_n ? NOM_TRIM : trim_code;
    assign sample = {level, 2'b00};
    always_ff @(posedge clk) begin
        lag_ff <= lag_ff + 9'h001;
        // Slow output settles every 512 cycles, still well inside one step
        if (!slow || lag_ff == 9'h000) begin
            sense <= {level, 2'b00};
        end
    end
endmodule // smfm_conv_model
`default_nettype wire

//--- sim/smfm_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module smfm_core_bench;
    import smfm_pkg::*;
    logic clk, sys_rst, cmd_strobe, latch_clear, margin_raise_pin, margin_lower_pin;
    logic monitor_input_one, monitor_input_two, ext_low, slow, trim_oe_n, vref_sel_high;
    logic fault_oe_n, ready_oe_n, fault_out, ready_out;
    logic [1:0] cmd;
    logic [ADC_W-1:0] set_high, set_low, set_nominal, sense, sample;
    logic [TRIM_W-1:0] trim_code;
    smfm_cfg_t cfg;
    smfm_stat_t status;
    int bad_count = 0;
    int compares = 0;
    int cyc_cnt = 0;
    int n;
    // Rows: mode[7:6] in one[5] in two[4] vref[3] live[2:1] fault wire[0]
    logic [7:0] rows [5] = '{8'h31, 8'h1A, 8'hD4, 8'hBC, 8'hC1};
    wire logic ready_in = ready_oe_n & ~ext_low;
    smfm_core DUT (.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .set_high(set_high),
        .set_low(set_low), .set_nominal(set_nominal), .cmd(cmd), .cmd_strobe(cmd_strobe),
        .latch_clear(latch_clear), .margin_raise_pin(margin_raise_pin),
        .margin_lower_pin(margin_lower_pin), .supply_sense_input(sense), .trim_sample(sample),
        .monitor_input_one(monitor_input_one), .monitor_input_two(monitor_input_two),
        .ready_in(ready_in), .trim_code(trim_code), .trim_oe_n(trim_oe_n),
        .vref_sel_high(vref_sel_high), .fault_out(fault_out), .fault_oe_n(fault_oe_n),
        .ready_out(ready_out), .ready_oe_n(ready_oe_n), .status(status));
    smfm_conv_model u_conv (.clk(clk), .slow(slow), .trim_code(trim_code),
        .trim_oe_n(trim_oe_n), .sense(sense), .sample(sample));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic send(input logic [1:0] c);
        cyc(1);
        cmd <= c;
        cmd_strobe <= 1'b1;
        cyc(1);
        cmd_strobe <= 1'b0;
    endtask
    task automatic wait_done(output int k);
        k = 0;
        // Outputs settle after the edge; never read them at the edge itself
        #1;
        while (status.margin_done !== 1'b1 && k < 50000) begin
            cyc(1);
            #1;
            k++;
        end
        `CHK("done", 1'b1, status.margin_done)
    endtask
    task automatic finish_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 95000) begin
            bad_count++;
            finish_test;
        end
    end
    initial begin
        {cmd_strobe, latch_clear, margin_raise_pin, margin_lower_pin, ext_low, slow} <= '0;
        {monitor_input_one, monitor_input_two} <= '0;
        {set_high, set_low, set_nominal} <= {10'h10C, 10'h0F8, 10'h100};
        cmd <= CMD_OFF;
        cfg <= '0;
        sys_rst <= 1'b1;
        cyc(5);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            cyc(1);
            {cfg.over_voltage_mode, monitor_input_one, monitor_input_two} <= rows[i][7:4];
            cfg.vref_high <= rows[i][3];
            cyc(9);
            #1;
            `CHK("vref", rows[i][3], vref_sel_high)
            `CHK("live", rows[i][2:1], status.live_fault)
            `CHK("fault", rows[i][0], fault_oe_n)
        end
        cyc(1);
        // Configuration only changes while idle
        {cfg.fault_off_margin, cfg.ready_active_high, cfg.latch_on_ready} <= 3'h7;
        monitor_input_one <= 1'b1;
        send(CMD_NOMINAL);
        wait_done(n);
        `CHK("nom", 3'h5, {status.holdoff_enable, fault_oe_n, ready_oe_n})
        `CHK("odrain", 2'h0, {fault_out, ready_out})
        monitor_input_two <= 1'b1;
        cyc(10);
        ext_low <= 1'b1;
        cyc(10);
        #1;
        `CHK("rdylatch", 2'h3, status.latched_fault)
        cyc(1);
        ext_low <= 1'b0;
        send(CMD_HIGH);
        cyc(2);
        #1;
        `CHK("start", 2'h2, {status.margining, trim_oe_n})
        `CHK("seed", 8'h40, trim_code)
        wait_done(n);
        `CHK("high", 8'h43, trim_code)
        `CHK("pace", 1'b1, n >= 29990 && n <= 40010)
        `CHK("mute", 2'h1, {status.holdoff_enable, fault_oe_n})
        send(CMD_OFF);
        cyc(3);
        #1;
        `CHK("off", 2'h1, {status.margining, trim_oe_n})
        cyc(1);
        slow <= 1'b1;
        send(CMD_LOW);
        wait_done(n);
        `CHK("low", 8'h3E, trim_code)
        cyc(1);
        sys_rst <= 1'b1;
        cyc(5);
        #1;
        `CHK("rst", 18'h3_8000, {trim_oe_n, fault_oe_n, ready_oe_n, trim_code, status})
        cyc(1);
        sys_rst <= 1'b0;
        {monitor_input_one, monitor_input_two, cfg.latch_on_ready} <= '0;
        cyc(10);
        monitor_input_one <= 1'b1;
        cyc(10);
        #1;
        `CHK("latch", 2'h1, status.latched_fault)
        cyc(1);
        latch_clear <= 1'b1;
        cyc(1);
        latch_clear <= 1'b0;
        cyc(10);
        #1;
        `CHK("cleared", 2'h0, status.latched_fault)
        cyc(1);
        monitor_input_one <= 1'b0;
        cyc(20);
        // Filter goes on only once the old fault has cleared unfiltered
        cfg.glitch_sel <= 2'h1;
        monitor_input_one <= 1'b1;
        cyc(300);
        monitor_input_one <= 1'b0;
        #1;
        `CHK("short", 1'b1, fault_oe_n)
        cyc(20);
        monitor_input_one <= 1'b1;
        cyc(GLITCH_CYC_1 + 20);
        #1;
        `CHK("long", 1'b0, fault_oe_n)
        cyc(1);
        margin_raise_pin <= 1'b1;
        cyc(2000);
        #1;
        `CHK("pindly", 1'b0, status.margining)
        finish_test;
    end
endmodule // smfm_core_bench
`default_nettype wire
